// ---- dsfs_pkg.sv ----
package dsfs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned RECOVER_MS = 100;
	localparam int unsigned RECOVER_TICKS = RECOVER_MS * 1000 / TICK_US;
	localparam int unsigned NORMAL_RUN_MIN = 10;
	localparam int unsigned NORMAL_RUN_TICKS =
		NORMAL_RUN_MIN * 60_000 * 1000 / TICK_US;
	localparam int unsigned INTERVAL_UNIT_MS = 100;
	localparam int unsigned INTERVAL_UNIT_TICKS =
		INTERVAL_UNIT_MS * 1000 / TICK_US;

	// ----------------------------------------
	// Levels and ranges
	// ----------------------------------------
	localparam logic [15:0] STALL_MIN_FREQ = 16'h003c;
	localparam logic [15:0] DECEL_LVL_MIN = 16'h014a;
	localparam logic [15:0] DECEL_LVL_MAX = 16'h019a;
	localparam logic [8:0] DECEL_LVL_RST = 9'h18b;
	localparam logic [15:0] RUN_LVL_MIN = 16'h001e;
	localparam logic [15:0] RUN_LVL_MAX = 16'h0096;
	localparam logic [7:0] RUN_HYST = 8'h02;
	localparam logic [1:0] RUN_SEL_RST = 2'h1;
	localparam logic [1:0] RUN_SEL_MAX = 2'h2;
	localparam logic [1:0] DECEL_SECOND = 2'h1;
	localparam logic [15:0] DET_LVL_RST = 16'h012c;
	localparam logic [7:0] DET_WIDTH_RST = 8'h14;
	localparam logic [15:0] DET_WIDTH_MIN = 16'h0001;
	localparam logic [15:0] DET_WIDTH_MAX = 16'h00ff;
	localparam logic [3:0] LOSS_NUM = 4'h9;
	localparam logic [3:0] LOSS_DEN = 4'ha;
	localparam logic [15:0] LOSS_TIME_MIN = 16'h0014;
	localparam logic [15:0] LOSS_TIME_MAX = 16'h0190;
	localparam logic [8:0] LOSS_TIME_RST = 9'h014;
	localparam logic [15:0] SUBST_MAX = 16'h03e8;
	localparam logic [9:0] SUBST_RST = 10'h320;
	localparam logic [25:0] SUBST_DIV = 26'h0000_3e8;
	localparam logic [3:0] LIMIT_MAX = 4'ha;
	localparam logic [3:0] LIMIT_RST = 4'h0;
	localparam logic [15:0] INTERVAL_MIN = 16'h0005;
	localparam logic [15:0] INTERVAL_MAX = 16'h1770;
	localparam logic [12:0] INTERVAL_RST = 13'h0064;

	// ----------------------------------------
	// Function codes
	// ----------------------------------------
	localparam logic [4:0] FN_AGREE = 5'h02;
	localparam logic [4:0] FN_USER_AGREE = 5'h03;
	localparam logic [4:0] FN_REF_LOSS = 5'h09;
	localparam logic [4:0] FN_RESTART = 5'h0e;
	localparam logic [4:0] FN_FDET_ONE = 5'h10;
	localparam logic [4:0] FN_FDET_TWO = 5'h11;
	localparam logic [3:0] AFN_STALL_LVL = 4'h7;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STALL = 8'h00;
	localparam logic [7:0] ADDR_FREQ = 8'h04;
	localparam logic [7:0] ADDR_LOSS = 8'h08;
	localparam logic [7:0] ADDR_RESTART = 8'h0c;
	localparam logic [7:0] ADDR_MAXF = 8'h10;
	localparam logic [7:0] ADDR_FUNC = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam int unsigned NUM_TERM = 4;
	localparam int unsigned NUM_ANA = 2;
	localparam int unsigned NUM_FAULT = 15;

	typedef struct packed {
		logic [11:0] rsv;
		logic        heavyDuty;
		logic [1:0]  runSel;
		logic [7:0]  runLvl;
		logic [8:0]  decelLvl;
	} dsfs_stall_reg_type;

	typedef struct packed {
		logic [6:0]  rsv;
		logic        lossSel;
		logic [7:0]  detWidth;
		logic [15:0] detLevel;
	} dsfs_freq_reg_type;

	typedef struct packed {
		logic [12:0] rsv;
		logic [8:0]  lossTime;
		logic [9:0]  subst;
	} dsfs_loss_reg_type;

	typedef struct packed {
		logic [14:0] rsv;
		logic [12:0] interval;
		logic [3:0]  limit;
	} dsfs_restart_reg_type;

	typedef struct packed {
		logic [15:0] maxTwo;
		logic [15:0] maxOne;
	} dsfs_maxf_reg_type;

	typedef struct packed {
		logic [3:0]       rsv;
		logic [1:0][3:0]  anaFn;
		logic [3:0][4:0]  termFn;
	} dsfs_func_reg_type;

	typedef struct packed {
		logic [17:0] rsv;
		logic        hvClass;
		logic [3:0]  termOut;
		logic        holdFreq;
		logic        stallRun;
		logic        refLoss;
		logic        restartActive;
		logic [3:0]  attempts;
		logic        lockout;
	} dsfs_status_type;

	localparam dsfs_stall_reg_type STALL_RST =
		'{12'h000, 1'b0, RUN_SEL_RST, 8'h00, DECEL_LVL_RST};
	localparam dsfs_freq_reg_type FREQ_RST =
		'{7'h00, 1'b0, DET_WIDTH_RST, DET_LVL_RST};
	localparam dsfs_loss_reg_type LOSS_RST =
		'{13'h0000, LOSS_TIME_RST, SUBST_RST};
	localparam dsfs_restart_reg_type RESTART_RST =
		'{15'h0000, INTERVAL_RST, LIMIT_RST};

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [9:0]       busVolt;
		logic [7:0]       outCurrent;
		logic [15:0]      outFreq;
		logic [15:0]      freqRef;
		logic [1:0][7:0]  anaIn;
	} dsfs_meas_type;

	typedef struct packed {
		logic       decelerating;
		logic       running;
		logic [1:0] decelSel;
		logic       motorTwo;
		logic       diagDone;
		logic       diagPass;
		logic       searchDone;
	} dsfs_drive_type;

	typedef struct packed {
		logic        holdFreq;
		logic        stallDecel;
		logic [1:0]  decelTimeSel;
		logic [15:0] freqCmd;
		logic        runRequest;
		logic        diagRequest;
		logic        speedSearch;
		logic        lockout;
	} dsfs_ctrl_type;

	typedef enum logic [2:0] {
		RS_RUN, RS_WAIT, RS_DIAG, RS_SEARCH, RS_LOCK
	} dsfs_restart_type;

endpackage

// ---- dsfs_plant.sv ----
`timescale 1ns/1ps
module dsfs_plant (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire dsfs_pkg::dsfs_ctrl_type  ctrl,
	input  wire logic                     decel,
	output dsfs_pkg::dsfs_drive_type      drive
);
	import dsfs_pkg::*;
	// ----------------
	// Power stage
	// ----------------
	// Diagnosis always passes; slow answers not modelled to save size
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive <= '0;
		end else begin
			drive <= '{decel, ctrl.runRequest, 2'h3, 1'b0,
				ctrl.diagRequest && !drive.diagDone, 1'b1, ctrl.speedSearch};
		end
	end
endmodule

// ---- dsfs_supervisor.sv ----
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Hold frequency in deceleration while bus voltage exceeds the stall level.
// - Double the deceleration stall level on the higher supply class.
// - No run stall action while output frequency is below 6 Hz.
// - Run stall select 0..2, default 1; zero means no run action.
// - Select 1: current over level decelerates with the active decel time.
// - Select 2: as select 1 but always second decel time.
// - Run stall level 30..150 percent, default by duty rating.
// - Analog input with code 7 caps the effective run stall level.
// - Terminal codes 3,16,17 use detection level and width; code 2 uses the width only.
// - Flag reference loss when it drops under 90% within the window.
// - Loss window settable 20..400 ms, default 20 ms.
// - Terminal code 9 asserts while reference loss is flagged.
// - Loss select 1 runs at substitute percent of max frequency.
// - Loss select 0 keeps following the reference, no substitute.
// - Motor two scales the substitute against its own maximum.
// - On fault withdraw the run request, then self diagnose.
// - After a passing diagnosis restart with speed search.
// - Only the listed fault classes may auto restart.
// - Terminal code 14 signals fault restart activity.
// - Count attempts to limit 0..10, then stop for manual clear.
// - Counter clears after 10 minutes normal run, manual reset, power cycle.
// - Wait the restart interval 0.5..600.0 s between attempts.
module dsfs_supervisor
	import dsfs_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter int unsigned NORMAL_LEN = NORMAL_RUN_TICKS,
	parameter logic [7:0] RUN_LVL_ND = 8'h78,
	parameter logic [7:0] RUN_LVL_HD = 8'h96,
	parameter logic [15:0] MAXF_RST = 16'h0258
) (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire dsfs_pkg::dsfs_meas_type  meas,
	input  wire dsfs_pkg::dsfs_drive_type drive,
	input  wire logic [14:0]              faultPins,
	input  wire logic                     highVoltStrap,
	output dsfs_pkg::dsfs_ctrl_type       ctrl,
	output logic      [3:0]               termOut
);
	import dsfs_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dsfs_stall_reg_type   cfgStall;
		dsfs_freq_reg_type    cfgFreq;
		dsfs_loss_reg_type    cfgLoss;
		dsfs_restart_reg_type cfgRestart;
		dsfs_maxf_reg_type    cfgMaxf;
		dsfs_func_reg_type    cfgFunc;
		logic [31:0]          rdata;
		logic                 hvClass;
		logic                 holdFreq;
		logic                 stallRun;
		logic [7:0]           recoverCnt;
		logic                 agreeRef;
		logic                 agreeUser;
		logic                 fdetOne;
		logic                 fdetTwo;
		logic [15:0]          refHold;
		logic [8:0]           winCnt;
		logic                 refLoss;
		logic [15:0]          freqCmd;
		dsfs_restart_type     rsState;
		logic [3:0]           attempts;
		logic                 restarted;
		logic [19:0]          normalCnt;
		logic [12:0]          intervalCnt;
		logic [6:0]           unitCnt;
		logic [3:0]           termOut;
		logic                 runReq;
		logic                 diagReq;
		logic                 speedSearch;
		logic                 lockout;
	} dsfs_sup_state_type;

	dsfs_sup_state_type s_q;
	dsfs_sup_state_type s_d;

	if (NORMAL_LEN < 2 || NORMAL_LEN > 20'hf_ffff) begin : g_chk
		$error("dsfs_supervisor normal run length out of range");
	end

	function automatic logic [15:0] clampv(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ----------------------------------------
	// Inputs and ticks
	// ----------------------------------------
	logic        tick;
	logic [15:0] pinSync;

	dsfs_tick #(
		.CYCLES(TICK_LEN)
	) u_tick (
		.clk   (clk),
		.resetn(resetn),
		.tick  (tick)
	);

	// Fault lines and strap arrive from the power stage, unsynchronised
	dsfs_sync #(
		.WIDTH(16)
	) u_sync (
		.clk   (clk),
		.resetn(resetn),
		.din   ({highVoltStrap, faultPins}),
		.dout  (pinSync)
	);

	// ----------------------------------------
	// Effective settings
	// ----------------------------------------
	logic [9:0]  decelLim;
	logic [7:0]  runLvl;
	logic [7:0]  runHyst;
	logic [15:0] detWidth;
	logic [15:0] lossTime;
	logic [15:0] interval;
	logic [15:0] maxFreq;
	logic [25:0] substProd;
	logic [15:0] substFreq;
	logic        faultNow;
	logic        restartable;
	logic        wrEn;
	logic        addrOk;
	logic        restartBusy;
	logic [3:0]  termNext;
	logic [31:0] rdMux;
	logic [15:0] decelClamp;
	logic [15:0] runClamp;
	logic [15:0] substClamp;
	logic [15:0] limitClamp;

	always_comb begin
		decelClamp = clampv({7'h00, s_q.cfgStall.decelLvl},
			DECEL_LVL_MIN, DECEL_LVL_MAX);
		runClamp = clampv({8'h00, s_q.cfgStall.runLvl},
			RUN_LVL_MIN, RUN_LVL_MAX);
		substClamp = clampv({6'h00, s_q.cfgLoss.subst},
			16'h0000, SUBST_MAX);
		limitClamp = clampv({12'h000, s_q.cfgRestart.limit},
			16'h0000, {12'h000, LIMIT_MAX});
		decelLim = {1'b0, decelClamp[8:0]};
		if (s_q.hvClass) begin
			decelLim = {decelLim[8:0], 1'b0};
		end
		if (s_q.cfgStall.runLvl == 8'h00) begin
			runLvl = s_q.cfgStall.heavyDuty ? RUN_LVL_HD : RUN_LVL_ND;
		end else begin
			runLvl = runClamp[7:0];
		end
		for (int i = 0; i < NUM_ANA; i++) begin
			if (s_q.cfgFunc.anaFn[i] == AFN_STALL_LVL &&
				meas.anaIn[i] < runLvl) begin
				runLvl = meas.anaIn[i];
			end
		end
		runHyst = (runLvl > RUN_HYST) ? runLvl - RUN_HYST : 8'h00;
		detWidth = clampv({8'h00, s_q.cfgFreq.detWidth},
			DET_WIDTH_MIN, DET_WIDTH_MAX);
		lossTime = clampv({7'h00, s_q.cfgLoss.lossTime},
			LOSS_TIME_MIN, LOSS_TIME_MAX);
		interval = clampv({3'h0, s_q.cfgRestart.interval},
			INTERVAL_MIN, INTERVAL_MAX);
		maxFreq = drive.motorTwo ? s_q.cfgMaxf.maxTwo
			: s_q.cfgMaxf.maxOne;
		substProd = maxFreq * substClamp[9:0];
		substFreq = 16'(substProd / SUBST_DIV);
	end

	assign faultNow = |pinSync[14:0];
	// Bit 14 gathers every class that must never auto restart
	assign restartable = |pinSync[13:0] && !pinSync[14];
	assign restartBusy = s_q.rsState == RS_WAIT ||
		s_q.rsState == RS_DIAG || s_q.rsState == RS_SEARCH;

	// ----------------------------------------
	// Terminals
	// ----------------------------------------
	for (genvar g = 0; g < NUM_TERM; g++) begin : g_term
		always_comb begin
			case (s_q.cfgFunc.termFn[g])
				FN_AGREE: termNext[g] = s_q.agreeRef;
				FN_USER_AGREE: termNext[g] = s_q.agreeUser;
				FN_FDET_ONE: termNext[g] = s_q.fdetOne;
				FN_FDET_TWO: termNext[g] = s_q.fdetTwo;
				FN_REF_LOSS: termNext[g] = s_q.refLoss;
				FN_RESTART: termNext[g] = restartBusy;
				default: termNext[g] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		addrOk = 1'b1;
		case (paddr)
			ADDR_STALL: rdMux = s_q.cfgStall;
			ADDR_FREQ: rdMux = s_q.cfgFreq;
			ADDR_LOSS: rdMux = s_q.cfgLoss;
			ADDR_RESTART: rdMux = s_q.cfgRestart;
			ADDR_MAXF: rdMux = s_q.cfgMaxf;
			ADDR_FUNC: rdMux = s_q.cfgFunc;
			ADDR_CTRL: rdMux = 32'h0000_0000;
			ADDR_STATUS: rdMux = dsfs_status_type'{18'h0_0000,
				s_q.hvClass, s_q.termOut, s_q.holdFreq, s_q.stallRun,
				s_q.refLoss, restartBusy, s_q.attempts, s_q.lockout};
			default: begin
				rdMux = 32'h0000_0000;
				addrOk = 1'b0;
			end
		endcase
	end

	assign wrEn = psel && penable && pwrite && addrOk;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrOk;
	assign prdata = s_q.rdata;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [16:0] fHi;
	logic [16:0] fLo;
	logic [16:0] dRef;
	logic [16:0] dUser;
	logic [19:0] refNow;
	logic [19:0] refLim;

	always_comb begin
		s_d = s_q;
		fHi = {1'b0, s_q.cfgFreq.detLevel} + {1'b0, detWidth};
		fLo = {1'b0, s_q.cfgFreq.detLevel} - {1'b0, detWidth};
		dRef = (meas.outFreq > meas.freqRef)
			? {1'b0, meas.outFreq - meas.freqRef}
			: {1'b0, meas.freqRef - meas.outFreq};
		dUser = (meas.outFreq > s_q.cfgFreq.detLevel)
			? {1'b0, meas.outFreq - s_q.cfgFreq.detLevel}
			: {1'b0, s_q.cfgFreq.detLevel - meas.outFreq};
		refNow = meas.freqRef * LOSS_DEN;
		refLim = s_q.refHold * LOSS_NUM;
		if (psel && !penable) begin
			s_d.rdata = rdMux;
		end
		// Strap read as a level, only ever past the synchroniser
		s_d.hvClass = pinSync[15];
		s_d.termOut = termNext;
		if (tick) begin
			s_d.holdFreq = drive.decelerating &&
				meas.busVolt > decelLim;
			if (s_q.cfgStall.runSel == 2'h0 || !drive.running ||
				drive.decelerating ||
				meas.outFreq < STALL_MIN_FREQ) begin
				s_d.stallRun = 1'b0;
				s_d.recoverCnt = 8'h00;
			end else if (meas.outCurrent > runLvl) begin
				s_d.stallRun = 1'b1;
				s_d.recoverCnt = 8'h00;
			end else if (s_q.stallRun) begin
				if (meas.outCurrent >= runHyst) begin
					s_d.recoverCnt = 8'h00;
				end else if (s_q.recoverCnt ==
					8'(RECOVER_TICKS - 1)) begin
					s_d.stallRun = 1'b0;
					s_d.recoverCnt = 8'h00;
				end else begin
					s_d.recoverCnt = s_q.recoverCnt + 1'b1;
				end
			end
			s_d.agreeRef = dRef <= {1'b0, detWidth};
			s_d.agreeUser = dUser <= {1'b0, detWidth};
			if ({1'b0, meas.outFreq} <= {1'b0, s_q.cfgFreq.detLevel}) begin
				s_d.fdetOne = 1'b1;
			end else if ({1'b0, meas.outFreq} > fHi) begin
				s_d.fdetOne = 1'b0;
			end
			if (meas.outFreq >= s_q.cfgFreq.detLevel) begin
				s_d.fdetTwo = 1'b1;
			end else if (fLo[16] || {1'b0, meas.outFreq} < fLo) begin
				s_d.fdetTwo = 1'b0;
			end
			// Window restarts from the live value, so slow drift is not loss
			if (s_q.refLoss) begin
				if (refNow >= refLim) begin
					s_d.refLoss = 1'b0;
					s_d.refHold = meas.freqRef;
					s_d.winCnt = 9'h000;
				end
			end else if (refNow < refLim) begin
				s_d.refLoss = 1'b1;
			end else if ({7'h00, s_q.winCnt} + 16'h0001 >= lossTime) begin
				s_d.refHold = meas.freqRef;
				s_d.winCnt = 9'h000;
			end else begin
				s_d.winCnt = s_q.winCnt + 1'b1;
			end
			s_d.freqCmd = (s_q.cfgFreq.lossSel && s_q.refLoss)
				? substFreq : meas.freqRef;
		end
		case (s_q.rsState)
			RS_RUN: begin
				s_d.runReq = 1'b1;
				if (faultNow) begin
					s_d.runReq = 1'b0;
					s_d.intervalCnt = 13'h0000;
					s_d.unitCnt = 7'h00;
					if (restartable &&
						s_q.attempts < limitClamp[3:0]) begin
						s_d.rsState = RS_WAIT;
					end else begin
						s_d.rsState = RS_LOCK;
						s_d.lockout = 1'b1;
					end
				end else if (tick && s_q.restarted) begin
					if (s_q.normalCnt == 20'(NORMAL_LEN - 1)) begin
						s_d.attempts = 4'h0;
						s_d.restarted = 1'b0;
						s_d.normalCnt = 20'h0_0000;
					end else begin
						s_d.normalCnt = s_q.normalCnt + 1'b1;
					end
				end
			end
			RS_WAIT: begin
				if (tick) begin
					if (s_q.unitCnt == 7'(INTERVAL_UNIT_TICKS - 1)) begin
						s_d.unitCnt = 7'h00;
						s_d.intervalCnt = s_q.intervalCnt + 1'b1;
						if ({3'h0, s_q.intervalCnt} + 16'h0001 >=
							interval) begin
							s_d.rsState = RS_DIAG;
							s_d.diagReq = 1'b1;
						end
					end else begin
						s_d.unitCnt = s_q.unitCnt + 1'b1;
					end
				end
			end
			RS_DIAG: begin
				if (drive.diagDone) begin
					s_d.diagReq = 1'b0;
					s_d.attempts = s_q.attempts + 1'b1;
					s_d.intervalCnt = 13'h0000;
					s_d.unitCnt = 7'h00;
					if (drive.diagPass && !faultNow) begin
						s_d.rsState = RS_SEARCH;
						s_d.speedSearch = 1'b1;
						s_d.runReq = 1'b1;
						s_d.restarted = 1'b1;
						s_d.normalCnt = 20'h0_0000;
					end else if (s_q.attempts + 1'b1 <
						limitClamp[3:0]) begin
						s_d.rsState = RS_WAIT;
					end else begin
						s_d.rsState = RS_LOCK;
						s_d.lockout = 1'b1;
					end
				end
			end
			RS_SEARCH: begin
				if (drive.searchDone) begin
					s_d.speedSearch = 1'b0;
					s_d.rsState = RS_RUN;
				end
			end
			RS_LOCK: begin
				s_d.runReq = 1'b0;
			end
			default: begin
				s_d.rsState = RS_RUN;
			end
		endcase
		if (wrEn) begin
			case (paddr)
				ADDR_STALL: begin
					s_d.cfgStall = dsfs_stall_reg_type'(pwdata);
					s_d.cfgStall.rsv = 12'h000;
					if (pwdata[18:17] > RUN_SEL_MAX) begin
						s_d.cfgStall.runSel = s_q.cfgStall.runSel;
					end
				end
				ADDR_FREQ: s_d.cfgFreq = {7'h00, pwdata[24:0]};
				ADDR_LOSS: s_d.cfgLoss = {13'h0000, pwdata[18:0]};
				ADDR_RESTART: s_d.cfgRestart = {15'h0000, pwdata[16:0]};
				ADDR_MAXF: s_d.cfgMaxf = pwdata;
				ADDR_FUNC: s_d.cfgFunc = {4'h0, pwdata[27:0]};
				ADDR_CTRL: begin
					if (pwdata[0]) begin
						s_d.attempts = 4'h0;
						s_d.restarted = 1'b0;
						if (s_q.rsState == RS_LOCK && !faultNow) begin
							s_d.rsState = RS_RUN;
							s_d.lockout = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.cfgStall <= STALL_RST;
			s_q.cfgFreq <= FREQ_RST;
			s_q.cfgLoss <= LOSS_RST;
			s_q.cfgRestart <= RESTART_RST;
			s_q.cfgMaxf <= {MAXF_RST, MAXF_RST};
			s_q.rsState <= RS_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	assign ctrl.holdFreq = s_q.holdFreq;
	assign ctrl.stallDecel = s_q.stallRun;
	assign ctrl.decelTimeSel = (s_q.cfgStall.runSel == RUN_SEL_MAX)
		? DECEL_SECOND : drive.decelSel;
	assign ctrl.freqCmd = s_q.freqCmd;
	assign ctrl.runRequest = s_q.runReq;
	assign ctrl.diagRequest = s_q.diagReq;
	assign ctrl.speedSearch = s_q.speedSearch;
	assign ctrl.lockout = s_q.lockout;
	assign termOut = s_q.termOut;
endmodule

// ---- dsfs_supervisor_chk.sv ----
`timescale 1ns/1ps
module dsfs_supervisor_chk (
	input wire logic                     clk,
	input wire logic                     resetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic [7:0]               paddr,
	input wire logic                     pslverr,
	input wire dsfs_pkg::dsfs_meas_type  meas,
	input wire dsfs_pkg::dsfs_drive_type drive,
	input wire logic [14:0]              faultPins,
	input wire dsfs_pkg::dsfs_ctrl_type  ctrl
);
	import dsfs_pkg::*;
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence acc_s; psel && penable; endsequence
	sequence flt_s; $rose(|faultPins); endsequence
	bad_addr_a: assert property (
		acc_s ##0 paddr > ADDR_STATUS |-> pslverr) else $error("no slverr");
	fault_stop_a: assert property (
		flt_s |-> ##[1:4] !ctrl.runRequest) else $error("run kept on fault");
	diag_idle_a: assert property (
		ctrl.diagRequest |-> !ctrl.runRequest) else $error("diag while run");
	search_run_a: assert property (
		ctrl.speedSearch |-> ctrl.runRequest) else $error("search, no run");
	search_after_a: assert property (
		$rose(ctrl.speedSearch) |-> $past(ctrl.diagRequest))
		else $error("search without diagnosis");
	lock_quiet_a: assert property (
		ctrl.lockout |-> !ctrl.runRequest && !ctrl.speedSearch)
		else $error("run while locked out");
	hold_cause_a: assert property (
		$rose(ctrl.holdFreq) |-> $past(drive.decelerating)
		&& $past(meas.busVolt) >= DECEL_LVL_MIN[9:0]) else $error("bad hold");
	stall_freq_a: assert property (
		$rose(ctrl.stallDecel) |-> $past(meas.outFreq) >= STALL_MIN_FREQ)
		else $error("stall below minimum frequency");
endmodule

bind dsfs_supervisor dsfs_supervisor_chk u_dsfs_supervisor_chk (.clk,
	.resetn, .psel, .penable, .paddr, .pslverr, .meas, .drive, .faultPins,
	.ctrl);

// ---- dsfs_sync.sv ----
`timescale 1ns/1ps
module dsfs_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} dsfs_sync_state_type;

	dsfs_sync_state_type s_q;
	dsfs_sync_state_type s_d;

	if (WIDTH < 1) begin : g_chk
		$error("dsfs_sync width must be at least one");
	end

	always_comb begin
		s_d.first = din;
		s_d.second = s_q.first;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.second;
endmodule

// ---- dsfs_tick.sv ----
`timescale 1ns/1ps
module dsfs_tick #(
	parameter int unsigned CYCLES = 40000
) (
	input  wire logic clk,
	input  wire logic resetn,
	output logic      tick
);
	localparam int unsigned CW = $clog2(CYCLES);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          pulse;
	} dsfs_tick_state_type;

	dsfs_tick_state_type s_q;
	dsfs_tick_state_type s_d;

	if (CYCLES < 2) begin : g_chk
		$error("dsfs_tick needs at least two cycles per tick");
	end

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (s_q.count == CW'(CYCLES - 1)) begin
			s_d.count = '0;
			s_d.pulse = 1'b1;
		end else begin
			s_d.count = s_q.count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.pulse;
endmodule

// ---- tb_dsfs_supervisor.sv ----
`timescale 1ns/1ps
module tb_dsfs_supervisor;
	import dsfs_pkg::*;
	logic               clk = 1'b0, resetn = 1'b0, decel = 1'b0;
	logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic               highVoltStrap = 1'b0, pready, pslverr, errv;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0000_0000, prdata, rdv;
	logic [14:0]        faultPins = 15'h0000;
	logic [3:0]         termOut;
	dsfs_meas_type      meas = '0;
	dsfs_drive_type     drive;
	dsfs_ctrl_type      ctrl;
	dsfs_stall_reg_type s = STALL_RST;
	dsfs_func_reg_type  f = '0;
	int                 failures = 0, cmp_count = 0;

	always #12.5 clk = ~clk;
	dsfs_supervisor #(.TICK_LEN(8), .NORMAL_LEN(20)) u_dsfs_supervisor (
		.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .meas, .drive, .faultPins, .highVoltStrap, .ctrl,
		.termOut);
	dsfs_plant u_dsfs_plant (.clk, .resetn, .ctrl, .decel, .drive);
	// ----------------
	// Tasks
	// ----------------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chb(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk("read", e, rdv);
	endtask
	task automatic tk(input int n);
		repeat (n * 8) @(posedge clk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		#400000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(ADDR_STALL, STALL_RST);
		rd(ADDR_FREQ, FREQ_RST);
		rd(ADDR_LOSS, LOSS_RST);
		rd(8'h20, 32'h0000_0000);
		chb("slverr", 1'b1, errv);
		f.termFn[0] = FN_REF_LOSS;
		f.termFn[1] = FN_RESTART;
		f.termFn[2] = FN_USER_AGREE;
		apb(1'b1, ADDR_FUNC, f);
		apb(1'b1, ADDR_FREQ, FREQ_RST | 32'h0100_0000);
		apb(1'b1, ADDR_RESTART, 32'h0000_0051);
		decel <= 1'b1;
		meas.busVolt <= 10'h190;
		tk(3);
		chb("hold", 1'b1, ctrl.holdFreq);
		meas.busVolt <= 10'h186;
		tk(3);
		chb("hold", 1'b0, ctrl.holdFreq);
		decel <= 1'b0;
		meas.outFreq <= 16'h003b;
		meas.outCurrent <= 8'h82;
		tk(3);
		chb("stall", 1'b0, ctrl.stallDecel);
		meas.outFreq <= 16'h0064;
		tk(3);
		chb("stall", 1'b1, ctrl.stallDecel);
		chk("dsel", 32'h0000_0003, 32'(ctrl.decelTimeSel));
		chb("agree", 1'b0, termOut[2]);
		s.runSel = 2'h2;
		apb(1'b1, ADDR_STALL, s);
		chk("dsel", 32'(DECEL_SECOND), 32'(ctrl.decelTimeSel));
		apb(1'b1, ADDR_STALL, s | 32'h0006_0000);
		rd(ADDR_STALL, s);
		meas.outCurrent <= 8'h64;
		tk(50);
		meas.outCurrent <= 8'h77;
		tk(2);
		meas.outCurrent <= 8'h64;
		tk(60);
		chb("stall", 1'b1, ctrl.stallDecel);
		tk(50);
		chb("stall", 1'b0, ctrl.stallDecel);
		f.anaFn[0] = AFN_STALL_LVL;
		meas.anaIn[0] <= 8'h50;
		meas.outFreq <= 16'h012c;
		apb(1'b1, ADDR_FUNC, f);
		tk(3);
		chb("stall", 1'b1, ctrl.stallDecel);
		chb("agree", 1'b1, termOut[2]);
		meas.outCurrent <= 8'h00;
		meas.freqRef <= 16'h01f4;
		tk(30);
		meas.freqRef <= 16'h012c;
		for (int i = 0; i < 300 && termOut[0] !== 1'b1; i++) @(posedge clk);
		chb("loss", 1'b1, termOut[0]);
		tk(1);
		chk("fcmd", 32'h0000_01e0, 32'(ctrl.freqCmd));
		meas.freqRef <= 16'h01f4;
		tk(3);
		chb("loss", 1'b0, termOut[0]);
		chk("fcmd", 32'h0000_01f4, 32'(ctrl.freqCmd));
		faultPins[0] <= 1'b1;
		repeat (5) @(posedge clk);
		chb("run", 1'b0, ctrl.runRequest);
		faultPins[0] <= 1'b0;
		tk(10);
		chb("restart", 1'b1, termOut[1]);
		tk(480);
		chb("run", 1'b0, ctrl.runRequest);
		for (int i = 0; i < 5000 && ctrl.runRequest !== 1'b1; i++)
			@(posedge clk);
		chb("run", 1'b1, ctrl.runRequest);
		faultPins[0] <= 1'b1;
		tk(2);
		chb("lock", 1'b1, ctrl.lockout);
		faultPins[0] <= 1'b0;
		@(posedge clk);
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		tk(1);
		chb("lock", 1'b0, ctrl.lockout);
		faultPins[14] <= 1'b1;
		tk(2);
		chb("lock", 1'b1, ctrl.lockout);
		highVoltStrap <= 1'b1;
		decel <= 1'b1;
		meas.busVolt <= 10'h190;
		tk(3);
		chb("hold", 1'b0, ctrl.holdFreq);
		finish_test();
	end
endmodule
